// ---- logic/byte_fifo.sv ----
// synchronous first-in first-out byte store
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic clr_in,
	input wire logic push_in,
	input wire logic [WIDTH-1:0] data_in,
	input wire logic pop_in,
	output logic [WIDTH-1:0] data_out,
	output logic full_out,
	output logic empty_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [AW:0] count_r, count_nxt;
	logic do_push, do_pop;

	assign full_out = (count_r == FULL_CNT);
	assign empty_out = (count_r == '0);
	assign data_out = mem_r[rd_ptr_r];
	// a push into a full store is dropped, a pop of an empty one ignored
	assign do_push = push_in && !full_out;
	assign do_pop = pop_in && !empty_out;

	always_comb begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt = count_r;
		if (do_push) begin
			wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : AW'(wr_ptr_r + 1'b1);
		end
		if (do_pop) begin
			rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : AW'(rd_ptr_r + 1'b1);
		end
		if (do_push && !do_pop) begin
			count_nxt = (AW + 1)'(count_r + 1'b1);
		end else if (do_pop && !do_push) begin
			count_nxt = (AW + 1)'(count_r - 1'b1);
		end
		if (clr_in) begin
			wr_ptr_nxt = '0;
			rd_ptr_nxt = '0;
			count_nxt = '0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_nxt;
		end
	end

	// storage needs no reset: the count hides stale entries
	always_ff @(posedge clk_sys_in) begin
		if (do_push && !clr_in) begin
			mem_r[wr_ptr_r] <= data_in;
		end
	end
endmodule

// ---- logic/uart_host_bus_interface.sv ----
// parallel host port of the uart: selects, strobes, registers, buffers
`timescale 1ns/1ps
module uart_host_bus_interface
	import uart_host_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic reset_pin_in,
	input wire logic [REG_SEL_W-1:0] reg_select_in,
	input wire logic select_high_a_in,
	input wire logic select_high_b_in,
	input wire logic select_low_n_in,
	input wire logic addr_latch_strobe_in,
	input wire logic rd_strobe_hi_in,
	input wire logic rd_strobe_lo_n_in,
	input wire logic wr_strobe_hi_in,
	input wire logic wr_strobe_lo_n_in,
	input wire logic [DATA_W-1:0] host_data_bus_in,
	output logic [DATA_W-1:0] host_data_bus_out,
	output logic host_data_bus_oe_out,
	output logic xcvr_drive_off_n_out,
	output logic [DATA_W-1:0] tx_byte_out,
	output logic tx_valid_out,
	input wire logic tx_ready_in,
	input wire logic [DATA_W-1:0] rx_byte_in,
	input wire logic rx_valid_in,
	output logic rx_ready_out,
	output logic baud_tick_out,
	output logic serial_enable_out
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_meta_r, pin_sync_r, pin_prev_r;

	assign pin_raw = {reset_pin_in, wr_strobe_lo_n_in, wr_strobe_hi_in,
		rd_strobe_lo_n_in, rd_strobe_hi_in, addr_latch_strobe_in,
		select_low_n_in, select_high_b_in, select_high_a_in,
		reg_select_in, host_data_bus_in};

	// meta stage feeds only the sync stage
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			pin_meta_r <= PIN_IDLE;
			pin_sync_r <= PIN_IDLE;
			pin_prev_r <= PIN_IDLE;
		end else begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	logic core_clr;
	logic [DATA_W-1:0] bus_data;
	logic [REG_SEL_W-1:0] live_addr;
	logic live_sel_a, live_sel_b, live_sel_lo_n;
	logic als_rise, rd_hi, rd_lo_n, wr_hi_rise, wr_lo_rise;

	assign core_clr = pin_sync_r[P_RESET];
	assign bus_data = pin_sync_r[P_DATA +: DATA_W];
	assign live_addr = pin_sync_r[P_ADDR +: REG_SEL_W];
	assign live_sel_a = pin_sync_r[P_SEL_A];
	assign live_sel_b = pin_sync_r[P_SEL_B];
	assign live_sel_lo_n = pin_sync_r[P_SEL_LO_N];
	// edge sensitive: a strobe parked low never latches
	assign als_rise = pin_sync_r[P_ALS] && !pin_prev_r[P_ALS];
	assign rd_hi = pin_sync_r[P_RD_HI];
	assign rd_lo_n = pin_sync_r[P_RD_LO_N];
	assign wr_hi_rise = pin_sync_r[P_WR_HI] && !pin_prev_r[P_WR_HI];
	// low strobe commits at its trailing edge, when bus data is settled
	assign wr_lo_rise = pin_sync_r[P_WR_LO_N]
		&& !pin_prev_r[P_WR_LO_N];

	// ---------------------------------------------------------------
	// address latch and decode
	// ---------------------------------------------------------------
	logic lat_valid_r, lat_valid_nxt;
	logic [REG_SEL_W-1:0] lat_addr_r, lat_addr_nxt;
	logic [2:0] lat_sel_r, lat_sel_nxt;
	logic [REG_SEL_W-1:0] eff_addr;
	logic [2:0] eff_sel;
	logic selected, rd_act, wr_commit;

	always_comb begin
		lat_valid_nxt = lat_valid_r;
		lat_addr_nxt = lat_addr_r;
		lat_sel_nxt = lat_sel_r;
		if (als_rise) begin
			lat_valid_nxt = 1'b1;
			lat_addr_nxt = live_addr;
			lat_sel_nxt = {live_sel_lo_n, live_sel_b, live_sel_a};
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || core_clr) begin
			lat_valid_r <= 1'b0;
			lat_addr_r <= '0;
			lat_sel_r <= 3'h4;
		end else begin
			lat_valid_r <= lat_valid_nxt;
			lat_addr_r <= lat_addr_nxt;
			lat_sel_r <= lat_sel_nxt;
		end
	end

	// latched copy wins once captured, live pins otherwise
	assign eff_addr = lat_valid_r ? lat_addr_r : live_addr;
	assign eff_sel = lat_valid_r ? lat_sel_r :
		{live_sel_lo_n, live_sel_b, live_sel_a};
	assign selected = eff_sel[0] && eff_sel[1] && !eff_sel[2];
	// either read strobe alone is enough
	assign rd_act = selected && (rd_hi || !rd_lo_n);
	assign wr_commit = selected && (wr_hi_rise || wr_lo_rise);

	// ---------------------------------------------------------------
	// character buffers
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] tx_head, rx_head;
	logic tx_full, tx_empty, rx_full, rx_empty;
	logic tx_push, tx_pop, rx_push, rx_pop;
	logic rd_prev_r, rd_prev_nxt, rd_start;

	assign rd_start = rd_act && !rd_prev_r;
	assign tx_push = wr_commit && (eff_addr == REG_DATA);
	assign rx_pop = rd_start && (eff_addr == REG_DATA);
	// receive path is closed while the reset pin is high
	assign rx_push = rx_valid_in && !rx_full && !core_clr;

	byte_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH)
	) tx_fifo (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.clr_in(core_clr),
		.push_in(tx_push),
		.data_in(bus_data),
		.pop_in(tx_pop),
		.data_out(tx_head),
		.full_out(tx_full),
		.empty_out(tx_empty)
	);

	byte_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH)
	) rx_fifo (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.clr_in(core_clr),
		.push_in(rx_push),
		.data_in(rx_byte_in),
		.pop_in(rx_pop),
		.data_out(rx_head),
		.full_out(rx_full),
		.empty_out(rx_empty)
	);

	// ---------------------------------------------------------------
	// register file and read path
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] regs_r [REG_COUNT];
	logic [DATA_W-1:0] regs_nxt [REG_COUNT];
	logic [DATA_W-1:0] status, read_mux;
	logic [DATA_W-1:0] dout_r, dout_nxt;
	logic oe_r, oe_nxt, xcvr_drive_off_n_n_r, xcvr_drive_off_n_n_nxt;

	always_comb begin
		status = '0;
		status[STAT_RX_AVAIL_BIT] = !rx_empty;
		status[STAT_RX_FULL_BIT] = rx_full;
		status[STAT_TX_EMPTY_BIT] = tx_empty;
		status[STAT_TX_FULL_BIT] = tx_full;
	end

	always_comb begin
		unique case (eff_addr)
			REG_DATA: read_mux = rx_empty ? '0 : rx_head;
			REG_STATUS: read_mux = status;
			default: read_mux = regs_r[eff_addr];
		endcase
	end

	always_comb begin
		for (int i = 0; i < REG_COUNT; i++) begin
			regs_nxt[i] = regs_r[i];
		end
		// data and status slots are not plain storage
		if (wr_commit && eff_addr != REG_DATA && eff_addr != REG_STATUS) begin
			regs_nxt[eff_addr] = bus_data;
		end
		rd_prev_nxt = rd_act;
		// value is frozen at strobe start so a pop cannot change it mid-read
		dout_nxt = rd_start ? read_mux : dout_r;
		oe_nxt = rd_act;
		xcvr_drive_off_n_n_nxt = !rd_act;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || core_clr) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_r[i] <= REG_RESET;
			end
			rd_prev_r <= 1'b0;
			dout_r <= '0;
			oe_r <= 1'b0;
			xcvr_drive_off_n_n_r <= 1'b1;
		end else begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_r[i] <= regs_nxt[i];
			end
			rd_prev_r <= rd_prev_nxt;
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
			xcvr_drive_off_n_n_r <= xcvr_drive_off_n_n_nxt;
		end
	end

	// ---------------------------------------------------------------
	// baud prescaler
	// ---------------------------------------------------------------
	logic [1:0] pre_cnt_r, pre_cnt_nxt;
	logic tick_r, tick_nxt;
	logic pre_4x;

	assign pre_4x = regs_r[REG_CONFIG][PRESCALE_BIT];
	// 1x parks the counter so a switch to 4x starts a full period

	always_comb begin
		pre_cnt_nxt = 2'(pre_cnt_r + 1'b1);
		tick_nxt = 1'b1;
		if (pre_4x) begin
			tick_nxt = (pre_cnt_r == PRESCALE_4X_LAST);
		end else begin
			pre_cnt_nxt = PRESCALE_RESET;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || core_clr) begin
			pre_cnt_r <= PRESCALE_RESET;
			tick_r <= 1'b0;
		end else begin
			pre_cnt_r <= pre_cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	// ---------------------------------------------------------------
	// transmit output stage
	// ---------------------------------------------------------------
	logic hold_valid_r, hold_valid_nxt;
	logic [DATA_W-1:0] hold_r, hold_nxt;
	logic rx_ready_r, rx_ready_nxt, ser_en_r, ser_en_nxt;

	// refill when empty or when the held byte leaves this cycle
	assign tx_pop = !tx_empty && (!hold_valid_r || tx_ready_in);

	always_comb begin
		hold_valid_nxt = hold_valid_r;
		hold_nxt = hold_r;
		if (hold_valid_r && tx_ready_in) begin
			hold_valid_nxt = 1'b0;
		end
		if (tx_pop) begin
			hold_valid_nxt = 1'b1;
			hold_nxt = tx_head;
		end
		// one cycle stale; a push seen while full is dropped in the buffer
		rx_ready_nxt = !rx_full && !rx_push;
		ser_en_nxt = 1'b1;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || core_clr) begin
			hold_valid_r <= 1'b0;
			hold_r <= '0;
			rx_ready_r <= 1'b0;
			ser_en_r <= 1'b0;
		end else begin
			hold_valid_r <= hold_valid_nxt;
			hold_r <= hold_nxt;
			rx_ready_r <= rx_ready_nxt;
			ser_en_r <= ser_en_nxt;
		end
	end

	assign host_data_bus_out = dout_r;
	assign host_data_bus_oe_out = oe_r;
	assign xcvr_drive_off_n_out = xcvr_drive_off_n_n_r;
	assign tx_byte_out = hold_r;
	assign tx_valid_out = hold_valid_r;
	assign rx_ready_out = rx_ready_r;
	assign baud_tick_out = tick_r;
	assign serial_enable_out = ser_en_r;
endmodule

// ---- logic/uart_host_pkg.sv ----
// constants shared by the host port block and its buffers
package uart_host_pkg;
	localparam int REG_SEL_W = 3;
	localparam int DATA_W = 8;
	localparam int REG_COUNT = 8;
	localparam int FIFO_DEPTH = 16;
	// ---------------------------------------------------------------
	// internal register map
	// ---------------------------------------------------------------
	localparam logic [2:0] REG_DATA = 3'h0;
	localparam logic [2:0] REG_CONFIG = 3'h4;
	localparam logic [2:0] REG_STATUS = 3'h5;
	localparam int PRESCALE_BIT = 7;
	localparam int STAT_RX_AVAIL_BIT = 0;
	localparam int STAT_RX_FULL_BIT = 1;
	localparam int STAT_TX_EMPTY_BIT = 2;
	localparam int STAT_TX_FULL_BIT = 3;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ---------------------------------------------------------------
	// prescaler: 4x divide ends on this count
	// ---------------------------------------------------------------
	localparam logic [1:0] PRESCALE_4X_LAST = 2'h3;
	localparam logic [1:0] PRESCALE_RESET = 2'h0;
	// ---------------------------------------------------------------
	// pin vector layout after synchronising
	// ---------------------------------------------------------------
	localparam int PIN_W = 20;
	localparam int P_DATA = 0;
	localparam int P_ADDR = 8;
	localparam int P_SEL_A = 11;
	localparam int P_SEL_B = 12;
	localparam int P_SEL_LO_N = 13;
	localparam int P_ALS = 14;
	localparam int P_RD_HI = 15;
	localparam int P_RD_LO_N = 16;
	localparam int P_WR_HI = 17;
	localparam int P_WR_LO_N = 18;
	localparam int P_RESET = 19;
	// idle pin levels: strobes inactive, selects off, reset pin low
	localparam logic [19:0] PIN_IDLE = 20'h52000;
endpackage

// ---- testbench/host_cpu_model.sv ----
// host processor model driving the parallel port pins
`timescale 1ns/1ps
module host_cpu_model
	import uart_host_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic [DATA_W-1:0] dev_data_in,
	input wire logic dev_oe_in,
	output logic [REG_SEL_W-1:0] reg_select_out,
	output logic [2:0] selects_out,
	output logic als_out,
	output logic [3:0] strobes_out,
	output logic [DATA_W-1:0] bus_out
);
	localparam logic [3:0] IDLE = 4'h5;
	logic drv_r;
	logic [DATA_W-1:0] wd_r, last_r;
	// released bus shows the inverse of its last level, never a stale copy
	assign bus_out = dev_oe_in ? dev_data_in
		: (drv_r ? wd_r : ~last_r);
	always @(posedge clk_sys_in) last_r <= bus_out;
	// latch strobe rests low: live address and selects stay in use
	initial begin
		reg_select_out = 3'h0;
		selects_out = 3'h1;
		als_out = 1'b0;
		strobes_out = IDLE;
		drv_r = 1'b0;
		wd_r = 8'h00;
		last_r = 8'h00;
	end
	task automatic latch_addr(input logic [2:0] sel, input logic [2:0] cs);
		reg_select_out <= sel;
		selects_out <= cs;
		repeat (4) @(posedge clk_sys_in);
		als_out <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		als_out <= 1'b0;
		selects_out <= 3'h1;
		repeat (4) @(posedge clk_sys_in);
	endtask
	// strobes {rd_hi, rd_lo_n, wr_hi, wr_lo_n}; address held past commit
	task automatic access(input logic wr, input logic hi,
		input logic [2:0] sel, input logic [2:0] cs, input logic [7:0] wd,
		output logic [7:0] rd);
		reg_select_out <= sel;
		selects_out <= cs;
		wd_r <= wd;
		drv_r <= wr;
		repeat (4) @(posedge clk_sys_in);
		strobes_out <= wr ? (hi ? 4'h7 : 4'h4)
			: (hi ? 4'hD : 4'h1);
		repeat (5) @(posedge clk_sys_in);
		rd = bus_out;
		strobes_out <= IDLE;
		repeat (5) @(posedge clk_sys_in);
		drv_r <= 1'b0;
		selects_out <= 3'h1;
		repeat (2) @(posedge clk_sys_in);
	endtask
endmodule

// ---- testbench/test_uart_host_bus_interface.sv ----
// self-checking bench for the uart host port
`timescale 1ns/1ps
module test_uart_host_bus_interface import uart_host_pkg::*;;
	typedef struct {
		logic [2:0] sel;
		logic [7:0] d;
		logic whi;
		logic rhi;
	} row_s;
	localparam logic [2:0] ON = 3'h6;
	localparam logic [2:0] OFF = 3'h1;
	logic clk_sys_in, rst_n_in, reset_pin_in, tx_ready_in, rx_valid_in;
	logic [7:0] rx_byte_in, got, db_in, db_out, tx_byte;
	logic oe, drv_off_n, tx_valid, tick, ser_en, rx_ready, als;
	logic [2:0] sel, cs;
	logic [3:0] stb;
	int n_fail, checks;
	row_s rows [5] = '{'{3'h1, 8'hA5, 1'b0, 1'b1}, '{3'h2, 8'h5A, 1'b1, 1'b0},
		'{3'h3, 8'h01, 1'b0, 1'b0}, '{3'h6, 8'h80, 1'b1, 1'b1},
		'{3'h7, 8'hFF, 1'b0, 1'b1}};
	logic [2:0] bad [3] = '{3'h2, 3'h4, 3'h7};
	uart_host_bus_interface u_uart_host_bus_interface (
		.clk_sys_in, .rst_n_in, .reset_pin_in, .reg_select_in(sel),
		.select_high_a_in(cs[2]), .select_high_b_in(cs[1]),
		.select_low_n_in(cs[0]), .addr_latch_strobe_in(als),
		.rd_strobe_hi_in(stb[3]), .rd_strobe_lo_n_in(stb[2]),
		.wr_strobe_hi_in(stb[1]), .wr_strobe_lo_n_in(stb[0]),
		.host_data_bus_in(db_in), .host_data_bus_out(db_out),
		.host_data_bus_oe_out(oe), .xcvr_drive_off_n_out(drv_off_n),
		.tx_byte_out(tx_byte), .tx_valid_out(tx_valid), .tx_ready_in,
		.rx_byte_in, .rx_valid_in, .rx_ready_out(rx_ready),
		.baud_tick_out(tick), .serial_enable_out(ser_en));
	host_cpu_model u_host_cpu_model (.clk_sys_in, .dev_data_in(db_out),
		.dev_oe_in(oe), .reg_select_out(sel), .selects_out(cs),
		.als_out(als), .strobes_out(stb), .bus_out(db_in));
	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			n_fail++;
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d,
		input logic hi, input logic [2:0] c);
		u_host_cpu_model.access(1'b1, hi, a, c, d, got);
	endtask
	task automatic rd(input logic [2:0] a, input logic hi, input logic [7:0] e);
		u_host_cpu_model.access(1'b0, hi, a, ON, 8'h00, got);
		chk(got, e);
	endtask
	task automatic count_ticks(input logic [7:0] e);
		logic [7:0] c;
		c = 8'h00;
		repeat (40) begin
			@(posedge clk_sys_in);
			c = c + {7'h00, tick};
		end
		chk(c, e);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		rst_n_in = 1'b0;
		reset_pin_in = 1'b0;
		tx_ready_in = 1'b1;
		rx_valid_in = 1'b0;
		rx_byte_in = 8'h00;
		n_fail = 0;
		checks = 0;
		repeat (5) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		rd(3'h1, 1'b0, REG_RESET);
		rd(3'h7, 1'b1, REG_RESET);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].sel, rows[i].d, rows[i].whi, ON);
		end
		foreach (rows[i]) begin
			rd(rows[i].sel, rows[i].rhi, rows[i].d);
		end
		$display("test table done");
		// each select dropped in turn; none of these writes may land
		foreach (bad[i]) wr(3'h1, 8'h3C, 1'b0, bad[i]);
		rd(3'h1, 1'b0, 8'hA5);
		// reads while deselected; the checker sees the bus stay released
		foreach (bad[i]) u_host_cpu_model.access(1'b0, 1'b0, 3'h1, bad[i],
			8'h00, got);
		wr(REG_STATUS, 8'hFF, 1'b1, ON);
		rd(REG_STATUS, 1'b0, 8'h04);
		$display("test select done");
		tx_ready_in <= 1'b0;
		wr(REG_DATA, 8'h96, 1'b0, ON);
		chk(tx_byte, 8'h96);
		chk({7'h00, tx_valid}, 8'h01);
		tx_ready_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		chk({7'h00, tx_valid}, 8'h00);
		rx_byte_in <= 8'hC3;
		rx_valid_in <= 1'b1;
		@(posedge clk_sys_in);
		rx_valid_in <= 1'b0;
		rd(REG_DATA, 1'b1, 8'hC3);
		rd(REG_DATA, 1'b0, 8'h00);
		$display("test data done");
		// seventeen pushes into a sixteen-deep store; the last is dropped
		rx_valid_in <= 1'b1;
		for (int i = 0; i < 17; i++) begin
			rx_byte_in <= 8'h10 + i[7:0];
			@(posedge clk_sys_in);
		end
		rx_valid_in <= 1'b0;
		rd(REG_STATUS, 1'b0, 8'h07);
		chk({7'h00, rx_ready}, 8'h00);
		for (int i = 0; i < 16; i++) begin
			rd(REG_DATA, 1'b0, 8'h10 + i[7:0]);
		end
		rd(REG_STATUS, 1'b1, 8'h04);
		chk({7'h00, rx_ready}, 8'h01);
		$display("test buffer done");
		wr(REG_CONFIG, 8'h80, 1'b0, ON);
		count_ticks(8'h0A);
		wr(REG_CONFIG, 8'h00, 1'b1, ON);
		count_ticks(8'h28);
		$display("test prescale done");
		u_host_cpu_model.latch_addr(3'h3, ON);
		wr(3'h6, 8'h77, 1'b0, OFF);
		rd(3'h6, 1'b1, 8'h77);
		$display("test latch done");
		reset_pin_in <= 1'b1;
		repeat (6) @(posedge clk_sys_in);
		chk({7'h00, ser_en}, 8'h00);
		chk({7'h00, rx_ready}, 8'h00);
		reset_pin_in <= 1'b0;
		repeat (5) @(posedge clk_sys_in);
		rd(3'h3, 1'b0, REG_RESET);
		$display("test reset pin done");
		results();
	end
endmodule

// ---- testbench/uart_host_bus_interface_assertions.sv ----
// pin-level checker for the uart host port
`timescale 1ns/1ps
module uart_host_bus_interface_assertions
	import uart_host_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic reset_pin_in,
	input wire logic select_high_a_in,
	input wire logic select_high_b_in,
	input wire logic select_low_n_in,
	input wire logic addr_latch_strobe_in,
	input wire logic rd_strobe_hi_in,
	input wire logic rd_strobe_lo_n_in,
	input wire logic tx_ready_in,
	input wire logic [DATA_W-1:0] host_data_bus_out,
	input wire logic host_data_bus_oe_out,
	input wire logic xcvr_drive_off_n_out,
	input wire logic [DATA_W-1:0] tx_byte_out,
	input wire logic tx_valid_out,
	input wire logic baud_tick_out,
	input wire logic serial_enable_out
);
	logic sel_w, rd_w, latched_r, latched_nxt;
	logic [2:0] gap_r, gap_nxt;
	assign sel_w = select_high_a_in & select_high_b_in & ~select_low_n_in;
	assign rd_w = rd_strobe_hi_in | ~rd_strobe_lo_n_in;
	// once latched, live selects no longer decide; select checks stand down
	always_comb begin
		latched_nxt = latched_r | addr_latch_strobe_in;
		gap_nxt = (baud_tick_out || !serial_enable_out) ? 3'h0 : gap_r + 3'h1;
		if (!rst_n_in) begin
			latched_nxt = 1'b0;
			gap_nxt = 3'h0;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		latched_r <= latched_nxt;
		gap_r <= gap_nxt;
	end
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_read_held;
		(sel_w && rd_w && !latched_r && !reset_pin_in) [*6];
	endsequence
	sequence s_deselect_held;
		(!sel_w && !latched_r) [*5];
	endsequence
	a_read_drives: assert property (
		s_read_held |-> host_data_bus_oe_out && !xcvr_drive_off_n_out)
		else $error("held read strobe left the bus released");
	a_deselect_quiet: assert property (
		s_deselect_held |-> !host_data_bus_oe_out)
		else $error("bus driven while not selected");
	a_idle_released: assert property (
		(!rd_w) [*5] |-> !host_data_bus_oe_out)
		else $error("bus driven with no read strobe");
	a_drive_off_pair: assert property (
		host_data_bus_oe_out != xcvr_drive_off_n_out)
		else $error("drive-off output disagrees with bus enable");
	a_data_frozen: assert property (
		host_data_bus_oe_out && $past(host_data_bus_oe_out)
		|-> $stable(host_data_bus_out))
		else $error("read data changed during a read");
	a_tick_gap: assert property (
		serial_enable_out |-> gap_r < 3'h4)
		else $error("baud tick gap longer than four cycles");
	a_reset_quiet: assert property (
		reset_pin_in [*4] |=> !serial_enable_out
		&& !host_data_bus_oe_out && !tx_valid_out)
		else $error("outputs active during reset pin");
	a_tx_holds: assert property (
		disable iff (!rst_n_in || reset_pin_in)
		tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
		else $error("transmit byte dropped while stalled");
endmodule
bind uart_host_bus_interface uart_host_bus_interface_assertions u_chk (
	.clk_sys_in, .rst_n_in, .reset_pin_in, .select_high_a_in,
	.select_high_b_in, .select_low_n_in, .addr_latch_strobe_in,
	.rd_strobe_hi_in, .rd_strobe_lo_n_in, .tx_ready_in, .host_data_bus_out,
	.host_data_bus_oe_out, .xcvr_drive_off_n_out, .tx_byte_out,
	.tx_valid_out, .baud_tick_out, .serial_enable_out);
